// *** pkg/lhcs_pkg.sv ***
// constants for the local high-impedance control serializer (32 Mbps local mode)
// assumes a 50 MHz system clock and a sampled 16 MHz control bit clock
`default_nettype none
package lhcs_pkg;
  localparam int unsigned PERIODS_PER_FRAME = 2048;
  localparam int unsigned PERIOD_W          = 11;
  localparam int unsigned CHANNELS          = 512;
  localparam int unsigned CHAN_W            = 9;
  localparam int unsigned STREAMS           = 8;
  localparam int unsigned STREAM_W          = 3;
  localparam int unsigned WR_STREAM_W       = 4;
  localparam int unsigned UPPER_STREAMS     = 8;
  localparam int unsigned MEM_BITS          = STREAMS * CHANNELS;
  localparam int unsigned MEM_AW            = STREAM_W + CHAN_W;
  localparam int unsigned WORD_W            = WR_STREAM_W + CHAN_W + 1;
  localparam int unsigned FIFO_DEPTH        = 16;
  // control bit rate and stream rate in kbit/s
  localparam int unsigned CTL_RATE_KBPS     = 16384;
  localparam int unsigned STREAM_RATE_KBPS  = 32768;
  // period of stream 0 channel 0, and the slot value of period 1
  localparam logic [10:0] FIRST_SLOT_PERIOD = 11'h7f7;
  localparam logic [10:0] LAST_PERIOD       = 11'h000;
  localparam logic [10:0] PERIOD_ONE        = 11'h001;
  localparam logic [10:0] SLOT_OF_PERIOD_1  = 11'h00a;
  localparam logic [10:0] SLOT_RESET        = 11'h00a;
  localparam logic        SER_RESET         = 1'b0;
endpackage : lhcs_pkg
`default_nettype wire

// *** rtl/lhcs_serializer.sv ***
// fifo and per-channel high-impedance control serializer, 32 Mbps local mode
// assumes control clock, frame pulse and mode select arrive asynchronously
`default_nettype none

module lhcs_fifo #(
  parameter int unsigned WIDTH = lhcs_pkg::WORD_W,
  parameter int unsigned DEPTH = lhcs_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push = ce_in && in_valid_in && in_ready_out;
  assign pop  = ce_in && out_valid_out && out_ready_in;
  assign out_data_out = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      count_q       <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else if (ce_in) begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q       <= count_d;
      in_ready_out  <= (count_d != FULL_COUNT);
      out_valid_out <= (count_d != '0);
    end
  end
endmodule : lhcs_fifo

// Notes on behaviour
// - upper half of local output streams unused; their drive permits always zero
// - unused upper pins driven high or released, chosen by the mode select input
// - each serial control bit copies that channel's drive permit; zero means release
// - each control pin sends one bit per control clock period, 16.384 Mbps
// - pin 0 carries streams 0,2,4,6; pin 1 carries streams 1,3,5,7
// - all eight streams run at 32.768 Mbps; control pins stay at 16.384 Mbps
// - stream 0 channel 0 goes out on pin 0 in period 2039
// - streams 6 and 7 channel 0 go out on both pins in period 2042
// - channel advances every four periods, streams cycling in pairs within each group
// - stream 2 channel 511 goes out on pin 0 in period 2036
// - stream 3 channel 5 goes out on pin 1 in period 12
// - periods counted from the frame boundary, 2048 per frame, 2048 then 1
// - channel numbers are 32.768 Mbps channels, 0 to 511 per frame
// - with mode select high the control pins carry the permit values directly
module lhcs_serializer #(
  parameter int unsigned FIFO_DEPTH = lhcs_pkg::FIFO_DEPTH
) (
  input  wire logic                               clk_in,
  input  wire logic                               rst_b_in,
  input  wire logic                               ce_in,
  input  wire logic                               control_bit_clock_in,
  input  wire logic                               frame_pulse_in,
  input  wire logic                               local_unused_output_mode_in,
  input  wire logic                               permit_wr_valid_in,
  output logic                                    permit_wr_ready_out,
  input  wire logic [lhcs_pkg::WR_STREAM_W-1:0]   permit_wr_stream_in,
  input  wire logic [lhcs_pkg::CHAN_W-1:0]        permit_wr_channel_in,
  input  wire logic                               local_drive_permit_bit_in,
  output logic                                    local_hiz_control_serial0_out,
  output logic                                    local_hiz_control_serial1_out,
  output logic [lhcs_pkg::UPPER_STREAMS-1:0]      upper_stream_pin_out,
  output logic [lhcs_pkg::UPPER_STREAMS-1:0]      upper_stream_pin_oe_out,
  output logic                                    init_done_out
);
  typedef enum logic [0:0] {LHCS_CLEAR, LHCS_RUN} lhcs_state_t;

  lhcs_state_t                    state_q;
  logic [lhcs_pkg::MEM_AW-1:0]    clr_addr_q;
  logic                           permit_mem_q [0:lhcs_pkg::MEM_BITS-1];
  logic                           clk_meta_q, clk_sync_q, clk_prev_q;
  logic                           fp_meta_q, fp_sync_q;
  logic                           mode_meta_q, mode_sync_q;
  logic                           tick;
  logic [lhcs_pkg::PERIOD_W-1:0]  period_q;
  logic [lhcs_pkg::PERIOD_W-1:0]  period_d;
  logic [lhcs_pkg::PERIOD_W-1:0]  slot_q;
  logic [lhcs_pkg::PERIOD_W-1:0]  slot_d;
  logic [lhcs_pkg::WORD_W-1:0]    fifo_word;
  logic                           fifo_valid;
  logic                           fifo_pop_ready;
  logic                           mem_we;
  logic [lhcs_pkg::MEM_AW-1:0]    mem_waddr;
  logic                           mem_wbit;
  logic                           fifo_upper;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("fifo depth below 2 cannot serve the write path");
    end
  endgenerate

  // memory index of a slot for pin 0 or pin 1
  function automatic logic [lhcs_pkg::MEM_AW-1:0] slot_addr(
    input logic [lhcs_pkg::PERIOD_W-1:0] slot,
    input logic                          odd
  );
    slot_addr = {slot[1:0], odd, slot[10:2]};
  endfunction : slot_addr

  lhcs_fifo #(
    .WIDTH (lhcs_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .ce_in         (ce_in),
    .in_valid_in   (permit_wr_valid_in),
    .in_ready_out  (permit_wr_ready_out),
    .in_data_in    ({permit_wr_stream_in, permit_wr_channel_in, local_drive_permit_bit_in}),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop_ready),
    .out_data_out  (fifo_word)
  );

  // writes stall while the memory is being cleared
  assign fifo_pop_ready = (state_q == LHCS_RUN);
  assign fifo_upper     = fifo_word[lhcs_pkg::WORD_W-1];

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = clr_addr_q;
    mem_wbit  = 1'b0;
    if (state_q == LHCS_CLEAR) begin
      mem_we = ce_in;
    end else if (fifo_valid && !fifo_upper) begin
      mem_we    = ce_in;
      mem_waddr = fifo_word[lhcs_pkg::WORD_W-2:1];
      mem_wbit  = fifo_word[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      permit_mem_q[mem_waddr] <= mem_wbit;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q       <= LHCS_CLEAR;
      clr_addr_q    <= '0;
      init_done_out <= 1'b0;
    end else if (ce_in) begin
      case (state_q)
        LHCS_CLEAR: begin
          clr_addr_q <= clr_addr_q + 1'b1;
          if (clr_addr_q == '1) begin
            state_q       <= LHCS_RUN;
            init_done_out <= 1'b1;
          end
        end
        default: begin
          state_q <= LHCS_RUN;
        end
      endcase
    end
  end

  // two-flop synchronisers for the control clock, frame pulse and mode select
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_meta_q  <= 1'b0;
      clk_sync_q  <= 1'b0;
      clk_prev_q  <= 1'b0;
      fp_meta_q   <= 1'b0;
      fp_sync_q   <= 1'b0;
      mode_meta_q <= 1'b0;
      mode_sync_q <= 1'b0;
    end else if (ce_in) begin
      clk_meta_q  <= control_bit_clock_in;
      clk_sync_q  <= clk_meta_q;
      clk_prev_q  <= clk_sync_q;
      fp_meta_q   <= frame_pulse_in;
      fp_sync_q   <= fp_meta_q;
      mode_meta_q <= local_unused_output_mode_in;
      mode_sync_q <= mode_meta_q;
    end
  end

  assign tick = ce_in && clk_sync_q && !clk_prev_q;

  always_comb begin
    if (fp_sync_q) begin
      period_d = lhcs_pkg::PERIOD_ONE;
      slot_d   = lhcs_pkg::SLOT_OF_PERIOD_1;
    end else begin
      period_d = period_q + 1'b1;  // 2048 kept as 0, wraps to 1
      slot_d   = slot_q + 1'b1;
    end
  end

  // bits leave on the rising control edge; external buffers see a whole period
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      period_q                      <= lhcs_pkg::PERIOD_ONE;
      slot_q                        <= lhcs_pkg::SLOT_RESET;
      local_hiz_control_serial0_out <= lhcs_pkg::SER_RESET;
      local_hiz_control_serial1_out <= lhcs_pkg::SER_RESET;
    end else if (tick) begin
      period_q <= period_d;
      slot_q   <= slot_d;
      // same serial copy of the permit in both mode select states
      local_hiz_control_serial0_out <= permit_mem_q[slot_addr(slot_d, 1'b0)];
      local_hiz_control_serial1_out <= permit_mem_q[slot_addr(slot_d, 1'b1)];
    end
  end

  // upper stream pins: high drive when mode is high, released when low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upper_stream_pin_out    <= '0;
      upper_stream_pin_oe_out <= '0;
    end else if (ce_in) begin
      upper_stream_pin_out    <= '1;
      upper_stream_pin_oe_out <= {lhcs_pkg::UPPER_STREAMS{mode_sync_q}};
    end
  end

  // stream rate versus control rate: two stream bits per control bit
  localparam int unsigned RATE_RATIO = lhcs_pkg::STREAM_RATE_KBPS / lhcs_pkg::CTL_RATE_KBPS;
  generate
    if (RATE_RATIO != 2) begin : g_bad_rate
      $error("stream and control rates do not match 32 Mbps mode");
    end
  endgenerate

  upper_dropped_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == LHCS_RUN && fifo_valid && fifo_upper) |-> !mem_we)
    else $error("write to an unused upper stream reached memory");

  upper_pins_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in |=> upper_stream_pin_oe_out == {lhcs_pkg::UPPER_STREAMS{$past(mode_sync_q)}})
    else $error("upper pin enable does not follow the mode select");

  frame_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (tick && !fp_sync_q && period_q == lhcs_pkg::LAST_PERIOD) |=> period_q == 11'h001)
    else $error("period after 2048 is not 1");

  frame_restart_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (tick && fp_sync_q) |=> period_q == 11'h001 && slot_q == 11'h00a)
    else $error("frame pulse did not restart the period count");

  first_slot_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    period_q == lhcs_pkg::FIRST_SLOT_PERIOD |-> slot_q == 11'h000)
    else $error("stream 0 channel 0 not in period 2039");

  pair_six_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    period_q == 11'h7fa |-> slot_q == 11'h003)
    else $error("streams 6 and 7 channel 0 not in period 2042");

  last_chan_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    period_q == 11'h7f4 |-> slot_q == {9'h1ff, 2'h1})
    else $error("stream 2 channel 511 not in period 2036");

  chan_five_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    period_q == 11'h00c |-> slot_q == {9'h005, 2'h1})
    else $error("stream 3 channel 5 not in period 12");

  serial_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !tick |=> $stable(local_hiz_control_serial0_out) && $stable(local_hiz_control_serial1_out))
    else $error("control bit changed between control clock edges");

  slot_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (tick && !fp_sync_q) |=> slot_q == $past(slot_q) + 11'h001)
    else $error("slot did not advance by one");

  frame_cov: cover property (@(posedge clk_in) disable iff (!rst_b_in) tick && fp_sync_q);
  wrap_cov: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    tick && period_q == lhcs_pkg::LAST_PERIOD);
  write_cov: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    mem_we && state_q == LHCS_RUN);
  full_cov: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    permit_wr_valid_in && !permit_wr_ready_out);
endmodule : lhcs_serializer
`default_nettype wire

// *** test/lhcs_buffer_model.sv ***
// external tri-state buffer side: makes the control bit clock and frame pulse,
// records both control pins once per control clock period
// assumes the block updates its pins well inside each 160 ns period
`default_nettype none
module lhcs_buffer_model (
  input  wire logic serial0_in,
  input  wire logic serial1_in,
  output logic      control_bit_clock_out,
  output logic      frame_pulse_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rec0   [1:2048];
  logic rec1   [1:2048];
  int   period;
  int   frames;
  bit   synced;
  initial begin
    control_bit_clock_out = 1'b0;
    frame_pulse_out       = 1'b0;
    // start mid-frame so the first pulse is a resync of the block's count
    period = 1500;
    frames = 0;
    synced = 1'b0;
    // odd offset keeps the edges off the system clock phase
    #7;
    forever begin
      #80 control_bit_clock_out = 1'b1;
      // pins still hold the bits of the period that this edge closes
      if (synced) begin
        rec0[period] = serial0_in;
        rec1[period] = serial1_in;
      end
      if (frame_pulse_out) begin
        period = 1;
        if (synced) begin
          frames++;
        end
        synced = 1'b1;
      end else begin
        period++;
      end
      #80 control_bit_clock_out = 1'b0;
      // pulse straddles the edge that starts period 1
      frame_pulse_out = (period == 2048);
    end
  end
endmodule : lhcs_buffer_model
`default_nettype wire

// *** test/test_local_hiz_control_serializer_32m.sv ***
// self-checking bench for the serializer in 32 Mbps local mode
// assumes lhcs_pkg, lhcs_serializer and lhcs_buffer_model are compiled first
`default_nettype none
module test_local_hiz_control_serializer_32m;
  timeunit 1ns;
  timeprecision 100ps;
  localparam time TD = 2ns;
  logic        clk_in;
  logic        rst_b_in;
  logic        mode;
  logic        wr_valid;
  logic        wr_ready;
  logic [3:0]  wr_stream;
  logic [8:0]  wr_chan;
  logic        wr_bit;
  logic        ser0;
  logic        ser1;
  logic [7:0]  up_pin;
  logic [7:0]  up_oe;
  logic        init_done;
  logic        ctl_clk;
  logic        fp;
  logic        shadow [0:7][0:511];
  int          failures;
  int          compares;
  // words packed as stream, channel, permit; queued while memory clears
  localparam logic [13:0] WORDS [16] = '{14'h0001, 14'h1c01, 14'h1801, 14'h0bff,
    14'h0c0b, 14'h0403, 14'h10c9, 14'h17ff, 14'h03ff, 14'h19ff, 14'h1fff, 14'h0c01,
    14'h10c8, 14'h0a01, 14'h1403, 14'h07fd};

  lhcs_serializer u_dut (
    .clk_in                        (clk_in),
    .rst_b_in                      (rst_b_in),
    .ce_in                         (1'b1),
    .control_bit_clock_in          (ctl_clk),
    .frame_pulse_in                (fp),
    .local_unused_output_mode_in   (mode),
    .permit_wr_valid_in            (wr_valid),
    .permit_wr_ready_out           (wr_ready),
    .permit_wr_stream_in           (wr_stream),
    .permit_wr_channel_in          (wr_chan),
    .local_drive_permit_bit_in     (wr_bit),
    .local_hiz_control_serial0_out (ser0),
    .local_hiz_control_serial1_out (ser1),
    .upper_stream_pin_out          (up_pin),
    .upper_stream_pin_oe_out       (up_oe),
    .init_done_out                 (init_done)
  );

  lhcs_buffer_model u_model (
    .serial0_in            (ser0),
    .serial1_in            (ser1),
    .control_bit_clock_out (ctl_clk),
    .frame_pulse_out       (fp)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // called at a clock edge; returns at the edge where the word was taken
  task automatic put_word(input logic [13:0] w, input int bound, output bit took);
    int n;
    #TD;
    wr_stream = w[13:10];
    wr_chan   = w[9:1];
    wr_bit    = w[0];
    wr_valid  = 1'b1;
    took      = 1'b0;
    for (n = 0; n < bound && !took; n++) begin
      @(posedge clk_in);
      if (wr_ready === 1'b1) begin
        took = 1'b1;
      end
    end
    if (took && w[13] == 1'b0) begin
      shadow[w[12:10]][w[9:1]] = w[0];
    end
  endtask : put_word

  task automatic wait_frame;
    int start;
    int n;
    start = u_model.frames;
    for (n = 0; n < 20000 && u_model.frames == start; n++) begin
      @(posedge clk_in);
    end
    if (u_model.frames == start) begin
      failures++;
      $display("Error frame wait expected pulse seen none");
      results();
    end
  endtask : wait_frame

  // whole recorded frame against the shadow map, right after a boundary
  task automatic check_frame;
    int p;
    int idx;
    int ch;
    int s0;
    wait_frame();
    for (p = 1; p <= 2048; p++) begin
      idx = (p + 2048 - 2039) % 2048;
      ch  = idx / 4;
      s0  = 2 * (idx % 4);
      check("pin0 bit", {7'h00, shadow[s0][ch]}, {7'h00, u_model.rec0[p]});
      check("pin1 bit", {7'h00, shadow[s0 + 1][ch]}, {7'h00, u_model.rec1[p]});
    end
  endtask : check_frame

  // fifo fills during the clear, refuses, then drains into memory
  task automatic fill_during_clear;
    bit took;
    int i;
    int n;
    for (i = 0; i < 16; i++) begin
      put_word(WORDS[i], 10, took);
      check("queued word", 8'h01, {7'h00, took});
    end
    put_word(14'h2401, 50, took);
    check("refused word", 8'h00, {7'h00, took});
    #TD wr_valid = 1'b0;
    for (n = 0; n < 5000 && init_done !== 1'b1; n++) begin
      @(posedge clk_in);
    end
    check("init done", 8'h01, {7'h00, init_done});
    // upper stream write aliasing onto stream 1 would flip its channel 0
    put_word(14'h2401, 20, took);
    check("upper word taken", 8'h01, {7'h00, took});
    #TD wr_valid = 1'b0;
  endtask : fill_during_clear

  task automatic upper_pins(input logic level);
    #TD mode = level;
    repeat (5) @(posedge clk_in);
    check("upper pin data", 8'hff, up_pin);
    check("upper pin enable", {8{level}}, up_oe);
  endtask : upper_pins

  initial begin
    rst_b_in  = 1'b0;
    mode      = 1'b0;
    wr_valid  = 1'b0;
    wr_stream = 4'h0;
    wr_chan   = 9'h000;
    wr_bit    = 1'b0;
    failures  = 0;
    compares  = 0;
    foreach (shadow[s, c]) begin
      shadow[s][c] = 1'b0;
    end
    repeat (5) @(posedge clk_in);
    #TD rst_b_in = 1'b1;
    @(posedge clk_in);
    fill_during_clear();
    upper_pins(1'b0);
    // first boundary may land before all words are applied
    wait_frame();
    check_frame();
    upper_pins(1'b1);
    // mode high: pins still carry the permits unchanged
    check_frame();
    results();
  end
endmodule : test_local_hiz_control_serializer_32m
`default_nettype wire
